/* rtl/rcmg_pkg.sv */
package rcmg_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 18;
  localparam int          DATA_W    = 32;
  localparam int          REG_W     = 16;
  localparam int          IDX_W     = 16;
  localparam logic [1:0]  ALIGN_OK  = 2'h0;

  // ----------------------------------------------------------------
  // Front-end geometry
  // ----------------------------------------------------------------
  localparam int NUM_DIODE = 8;
  localparam int NUM_CHAN  = 4;
  localparam int NUM_POL   = 2;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_DIODE_AVG = 16'hbbad;
  localparam logic [IDX_W-1:0] IDX_CHAN_CUR  = 16'hbbb5;
  localparam logic [IDX_W-1:0] IDX_CHAN_AVG  = 16'hbbb9;
  localparam logic [IDX_W-1:0] IDX_POL_CUR   = 16'hbbbd;
  localparam logic [IDX_W-1:0] IDX_POL_AVG   = 16'hbbbf;
  localparam logic [IDX_W-1:0] IDX_POL_MIN   = 16'hbbc1;
  localparam logic [IDX_W-1:0] IDX_POL_MAX   = 16'hbbc3;
  localparam logic [IDX_W-1:0] IDX_TEMP      = 16'hbbc5;
  localparam logic [IDX_W-1:0] IDX_RSVD      = 16'hbbc6;
  localparam int               NUM_RSVD      = 2;
  localparam logic [IDX_W-1:0] IDX_GCV       = 16'hbbc8;
  localparam logic [IDX_W-1:0] IDX_RFT       = 16'hbbcc;
  localparam logic [IDX_W-1:0] IDX_LO_MON    = 16'hbbd0;
  localparam logic [IDX_W-1:0] IDX_LO_SET    = 16'hbbd1;
  localparam logic [IDX_W-1:0] IDX_LO_MIN    = 16'hbbd2;
  localparam logic [IDX_W-1:0] IDX_LO_MAX    = 16'hbbd3;
  localparam logic [IDX_W-1:0] IDX_GAIN_MODE = 16'hbc00;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int               MODE_LSB    = 14;
  localparam int               MODE_MSB    = 15;
  localparam logic [1:0]       MODE_MANUAL = 2'h0;
  localparam logic [1:0]       MODE_AUTO   = 2'h1;
  localparam logic [REG_W-1:0] REG_RESET   = 16'h0000;

  typedef logic [REG_W-1:0] rcmg_word_t;

endpackage : rcmg_pkg

/* rtl/rcmg_stat.sv */
`timescale 1ns/1ps
module rcmg_stat #(
  parameter int AVG_LOG = 8
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_valid,
  input  wire logic [rcmg_pkg::REG_W-1:0] i_sample,
  output logic      [rcmg_pkg::REG_W-1:0] o_avg,
  output logic      [rcmg_pkg::REG_W-1:0] o_min,
  output logic      [rcmg_pkg::REG_W-1:0] o_max,
  output logic                            o_done
);
  import rcmg_pkg::*;

  localparam int ACC_W = REG_W + AVG_LOG;

  // ----------------------------------------------------------------
  // Interval accumulation
  // ----------------------------------------------------------------
  // Power-of-two interval keeps the average a plain shift, no divider
  logic [AVG_LOG-1:0] cnt;
  logic [ACC_W-1:0]   acc;
  logic [REG_W-1:0]   run_min;
  logic [REG_W-1:0]   run_max;
  logic [ACC_W-1:0]   next_acc;
  logic [REG_W-1:0]   next_min;
  logic [REG_W-1:0]   next_max;
  logic               last;

  initial begin
    if (AVG_LOG < 1 || AVG_LOG > 16) begin
      $error("rcmg_stat: AVG_LOG out of range");
    end
  end

  assign next_acc = acc + ACC_W'(i_sample);
  assign next_min = (i_sample < run_min) ? i_sample : run_min;
  assign next_max = (i_sample > run_max) ? i_sample : run_max;
  assign last     = i_valid && (cnt == {AVG_LOG{1'b1}});

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt     <= '0;
      acc     <= '0;
      run_min <= '1;
      run_max <= '0;
    end else if (last) begin
      cnt     <= '0;
      acc     <= '0;
      run_min <= '1;
      run_max <= '0;
    end else if (i_valid) begin
      cnt     <= cnt + 1'b1;
      acc     <= next_acc;
      run_min <= next_min;
      run_max <= next_max;
    end
  end

  // ----------------------------------------------------------------
  // Interval results
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avg  <= REG_RESET;
      o_min  <= REG_RESET;
      o_max  <= REG_RESET;
      o_done <= 1'b0;
    end else begin
      o_done <= last;
      if (last) begin
        o_avg <= next_acc[ACC_W-1:AVG_LOG];
        o_min <= next_min;
        o_max <= next_max;
      end
    end
  end

  avg_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_done |-> (o_min <= o_avg) && (o_avg <= o_max))
    else $error("interval average outside min and max");

  interval_c: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_done);

endmodule : rcmg_stat

/* rtl/rcmg_regs.sv */
`timescale 1ns/1ps
module rcmg_regs #(
  parameter int                              AVG_LOG      = 8,
  parameter logic [rcmg_pkg::REG_W-1:0]      LO_MIN_LIMIT = 16'hfc18,
  parameter logic [rcmg_pkg::REG_W-1:0]      LO_MAX_LIMIT = 16'h03e8,
  parameter logic [rcmg_pkg::REG_W-1:0]      LO_SET_RESET = 16'h0000
) (
  input  wire logic                                             I_CLK_SYS,
  input  wire logic                                             I_RST_B,
  input  wire logic                                             I_PSEL,
  input  wire logic                                             I_PENABLE,
  input  wire logic                                             I_PWRITE,
  input  wire logic [rcmg_pkg::ADDR_W-1:0]                      I_PADDR,
  input  wire logic [rcmg_pkg::DATA_W-1:0]                      I_PWDATA,
  output logic      [rcmg_pkg::DATA_W-1:0]                      O_PRDATA,
  output logic                                                  O_PREADY,
  output logic                                                  O_PSLVERR,
  input  wire logic                                             I_PD_VALID,
  input  wire logic [rcmg_pkg::NUM_DIODE*rcmg_pkg::REG_W-1:0]   I_PD_CURRENT,
  input  wire logic [rcmg_pkg::REG_W-1:0]                       I_TEMP,
  input  wire logic [rcmg_pkg::REG_W-1:0]                       I_LO_POWER,
  output logic      [rcmg_pkg::NUM_CHAN*rcmg_pkg::REG_W-1:0]    O_GAIN_CTRL,
  output logic      [rcmg_pkg::NUM_CHAN*rcmg_pkg::REG_W-1:0]    O_RF_TARGET,
  output logic      [rcmg_pkg::NUM_CHAN-1:0]                    O_AGC_EN,
  output logic      [rcmg_pkg::REG_W-1:0]                       O_LO_SETPOINT
);
  import rcmg_pkg::*;

  initial begin
    if ($signed(LO_MIN_LIMIT) > $signed(LO_MAX_LIMIT) ||
        $signed(LO_SET_RESET) < $signed(LO_MIN_LIMIT) ||
        $signed(LO_SET_RESET) > $signed(LO_MAX_LIMIT)) begin
      $error("rcmg_regs: inconsistent set-point limits");
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic rcmg_word_t sat_add(input rcmg_word_t a, input rcmg_word_t b);
    logic [REG_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[REG_W] ? '1 : s[REG_W-1:0];
  endfunction : sat_add

  function automatic rcmg_word_t clamp(input rcmg_word_t v);
    if ($signed(v) < $signed(LO_MIN_LIMIT)) begin
      clamp = LO_MIN_LIMIT;
    end else if ($signed(v) > $signed(LO_MAX_LIMIT)) begin
      clamp = LO_MAX_LIMIT;
    end else begin
      clamp = v;
    end
  endfunction : clamp

  function automatic logic hit(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] base, input int n);
    hit = (idx >= base) && ((idx - base) < IDX_W'(n));
  endfunction : hit

  // ----------------------------------------------------------------
  // Photocurrent sums and interval statistics
  // ----------------------------------------------------------------
  rcmg_word_t diode_avg [NUM_DIODE];
  rcmg_word_t chan_cur  [NUM_CHAN];
  rcmg_word_t chan_avg  [NUM_CHAN];
  rcmg_word_t pol_cur   [NUM_POL];
  rcmg_word_t pol_avg   [NUM_POL];
  rcmg_word_t pol_min   [NUM_POL];
  rcmg_word_t pol_max   [NUM_POL];
  logic       chan_vld;
  logic       pol_vld;

  // Channel is the p and n diode pair, polarization the I and Q pair
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      chan_vld <= 1'b0;
      pol_vld  <= 1'b0;
      for (int c = 0; c < NUM_CHAN; c++) chan_cur[c] <= REG_RESET;
      for (int p = 0; p < NUM_POL; p++) pol_cur[p] <= REG_RESET;
    end else begin
      chan_vld <= I_PD_VALID;
      pol_vld  <= chan_vld;
      if (I_PD_VALID) begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          chan_cur[c] <= sat_add(I_PD_CURRENT[2*c*REG_W +: REG_W], I_PD_CURRENT[(2*c+1)*REG_W +: REG_W]);
        end
      end
      if (chan_vld) begin
        for (int p = 0; p < NUM_POL; p++) begin
          pol_cur[p] <= sat_add(chan_cur[2*p], chan_cur[2*p+1]);
        end
      end
    end
  end

  for (genvar d = 0; d < NUM_DIODE; d++) begin : g_diode
    rcmg_stat #(.AVG_LOG(AVG_LOG)) u_stat (
      .i_clk    (I_CLK_SYS),
      .i_rst_b  (I_RST_B),
      .i_valid  (I_PD_VALID),
      .i_sample (I_PD_CURRENT[d*REG_W +: REG_W]),
      .o_avg    (diode_avg[d]),
      .o_min    (),
      .o_max    (),
      .o_done   ()
    );
  end

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    rcmg_stat #(.AVG_LOG(AVG_LOG)) u_stat (
      .i_clk    (I_CLK_SYS),
      .i_rst_b  (I_RST_B),
      .i_valid  (chan_vld),
      .i_sample (chan_cur[c]),
      .o_avg    (chan_avg[c]),
      .o_min    (),
      .o_max    (),
      .o_done   ()
    );
  end

  for (genvar p = 0; p < NUM_POL; p++) begin : g_pol
    rcmg_stat #(.AVG_LOG(AVG_LOG)) u_stat (
      .i_clk    (I_CLK_SYS),
      .i_rst_b  (I_RST_B),
      .i_valid  (pol_vld),
      .i_sample (pol_cur[p]),
      .o_avg    (pol_avg[p]),
      .o_min    (pol_min[p]),
      .o_max    (pol_max[p]),
      .o_done   ()
    );
  end

  // ----------------------------------------------------------------
  // Sampled monitors
  // ----------------------------------------------------------------
  rcmg_word_t temp;
  rcmg_word_t lo_pow;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      temp   <= REG_RESET;
      lo_pow <= REG_RESET;
    end else begin
      temp   <= I_TEMP;
      lo_pow <= I_LO_POWER;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] idx;
  logic             aligned;
  logic             setup;
  logic             wr_en;

  assign idx      = I_PADDR[ADDR_W-1:2];
  assign aligned  = (I_PADDR[1:0] == ALIGN_OK);
  assign setup    = I_PSEL && !I_PENABLE;
  assign wr_en    = I_PSEL && I_PENABLE && I_PWRITE && aligned;
  // Zero wait states: data is staged in the setup cycle
  assign O_PREADY = 1'b1;

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  logic [1:0] mode [NUM_CHAN];
  rcmg_word_t gcv  [NUM_CHAN];
  rcmg_word_t rft  [NUM_CHAN];
  rcmg_word_t lo_set;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      for (int c = 0; c < NUM_CHAN; c++) mode[c] <= MODE_MANUAL;
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (wr_en && idx == IDX_W'(IDX_GAIN_MODE + c)) mode[c] <= I_PWDATA[MODE_MSB:MODE_LSB];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      for (int c = 0; c < NUM_CHAN; c++) gcv[c] <= REG_RESET;
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        // Writes outside manual gain are dropped silently, no bus error
        if (wr_en && idx == IDX_W'(IDX_GCV + c) && mode[c] == MODE_MANUAL) begin
          gcv[c] <= I_PWDATA[REG_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      for (int c = 0; c < NUM_CHAN; c++) rft[c] <= REG_RESET;
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (wr_en && idx == IDX_W'(IDX_RFT + c)) rft[c] <= I_PWDATA[REG_W-1:0];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      lo_set <= LO_SET_RESET;
    end else if (wr_en && idx == IDX_LO_SET) begin
      lo_set <= clamp(I_PWDATA[REG_W-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_GAIN_CTRL   <= '0;
      O_RF_TARGET   <= '0;
      O_AGC_EN      <= '0;
      O_LO_SETPOINT <= LO_SET_RESET;
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        O_GAIN_CTRL[c*REG_W +: REG_W] <= gcv[c];
        O_AGC_EN[c]                   <= (mode[c] == MODE_AUTO);
        // Target is held at zero unless automatic gain owns the channel
        O_RF_TARGET[c*REG_W +: REG_W] <= (mode[c] == MODE_AUTO) ? rft[c] : REG_RESET;
      end
      O_LO_SETPOINT <= lo_set;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  rcmg_word_t       next_rdata;
  logic             next_err;
  logic [IDX_W-1:0] off;

  always_comb begin
    next_rdata = REG_RESET;
    next_err   = 1'b0;
    off        = '0;
    if (!aligned) begin
      next_err = 1'b1;
    end else if (hit(idx, IDX_DIODE_AVG, NUM_DIODE)) begin
      off        = idx - IDX_DIODE_AVG;
      next_rdata = diode_avg[off[2:0]];
    end else if (hit(idx, IDX_CHAN_CUR, NUM_CHAN)) begin
      off        = idx - IDX_CHAN_CUR;
      next_rdata = chan_cur[off[1:0]];
    end else if (hit(idx, IDX_CHAN_AVG, NUM_CHAN)) begin
      off        = idx - IDX_CHAN_AVG;
      next_rdata = chan_avg[off[1:0]];
    end else if (hit(idx, IDX_POL_CUR, NUM_POL)) begin
      off        = idx - IDX_POL_CUR;
      next_rdata = pol_cur[off[0]];
    end else if (hit(idx, IDX_POL_AVG, NUM_POL)) begin
      off        = idx - IDX_POL_AVG;
      next_rdata = pol_avg[off[0]];
    end else if (hit(idx, IDX_POL_MIN, NUM_POL)) begin
      off        = idx - IDX_POL_MIN;
      next_rdata = pol_min[off[0]];
    end else if (hit(idx, IDX_POL_MAX, NUM_POL)) begin
      off        = idx - IDX_POL_MAX;
      next_rdata = pol_max[off[0]];
    end else if (idx == IDX_TEMP) begin
      next_rdata = temp;
    end else if (hit(idx, IDX_RSVD, NUM_RSVD)) begin
      next_rdata = REG_RESET;
    end else if (hit(idx, IDX_GCV, NUM_CHAN)) begin
      off        = idx - IDX_GCV;
      next_rdata = gcv[off[1:0]];
    end else if (hit(idx, IDX_RFT, NUM_CHAN)) begin
      off        = idx - IDX_RFT;
      next_rdata = rft[off[1:0]];
    end else if (idx == IDX_LO_MON) begin
      next_rdata = lo_pow;
    end else if (idx == IDX_LO_SET) begin
      next_rdata = lo_set;
    end else if (idx == IDX_LO_MIN) begin
      next_rdata = LO_MIN_LIMIT;
    end else if (idx == IDX_LO_MAX) begin
      next_rdata = LO_MAX_LIMIT;
    end else if (hit(idx, IDX_GAIN_MODE, NUM_CHAN)) begin
      off        = idx - IDX_GAIN_MODE;
      next_rdata = REG_RESET;
      next_rdata[MODE_MSB:MODE_LSB] = mode[off[1:0]];
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PRDATA  <= '0;
      O_PSLVERR <= 1'b0;
    end else if (setup) begin
      O_PRDATA  <= I_PWRITE ? '0 : {{(DATA_W-REG_W){1'b0}}, next_rdata};
      O_PSLVERR <= next_err;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);

  gcv_lock_a: assert property (wr_en && idx == IDX_GCV && mode[0] != MODE_MANUAL |=> $stable(gcv[0]))
    else $error("gain voltage changed outside manual gain");
  gcv_write_a: assert property (wr_en && idx == IDX_GCV && mode[0] == MODE_MANUAL
    |=> ##1 O_GAIN_CTRL[REG_W-1:0] == $past(I_PWDATA[REG_W-1:0], 2))
    else $error("manual gain voltage write not driven out");
  rft_apply_a: assert property (O_RF_TARGET[REG_W-1:0] != REG_RESET |-> O_AGC_EN[0])
    else $error("RF target applied outside automatic gain");
  lo_clamp_a: assert property ($signed(O_LO_SETPOINT) >= $signed(LO_MIN_LIMIT) &&
    $signed(O_LO_SETPOINT) <= $signed(LO_MAX_LIMIT))
    else $error("set-point beyond limits");
  lo_drive_a: assert property (wr_en && idx == IDX_LO_SET |=> ##1 O_LO_SETPOINT == clamp($past(I_PWDATA[REG_W-1:0], 2)))
    else $error("set-point not driven out");
  lo_mon_a: assert property (setup && !I_PWRITE && aligned && idx == IDX_LO_MON
    |=> O_PRDATA == {16'h0000, $past(I_LO_POWER, 2)})
    else $error("power monitor read mismatch");
  temp_read_a: assert property (setup && !I_PWRITE && aligned && idx == IDX_TEMP
    |=> O_PRDATA == {16'h0000, $past(I_TEMP, 2)})
    else $error("temperature read mismatch");
  rsvd_zero_a: assert property (setup && !I_PWRITE && aligned && hit(idx, IDX_RSVD, NUM_RSVD)
    |=> O_PRDATA == '0 && !O_PSLVERR)
    else $error("reserved word not zero");
  limit_read_a: assert property (setup && !I_PWRITE && aligned && idx == IDX_LO_MIN
    |=> O_PRDATA[REG_W-1:0] == LO_MIN_LIMIT)
    else $error("minimum limit read mismatch");
  limit_max_a: assert property (setup && !I_PWRITE && aligned && idx == IDX_LO_MAX
    |=> O_PRDATA[REG_W-1:0] == LO_MAX_LIMIT)
    else $error("maximum limit read mismatch");
  chan_sum_a: assert property (I_PD_VALID |=> chan_cur[0] ==
    sat_add($past(I_PD_CURRENT[REG_W-1:0]), $past(I_PD_CURRENT[2*REG_W-1:REG_W])))
    else $error("channel sum mismatch");

  gcv_ok_c:    cover property (wr_en && idx == IDX_GCV && mode[0] == MODE_MANUAL);
  gcv_block_c: cover property (wr_en && idx == IDX_GCV && mode[0] == MODE_AUTO);
  clamp_c:     cover property (wr_en && idx == IDX_LO_SET && $signed(I_PWDATA[REG_W-1:0]) > $signed(LO_MAX_LIMIT));
  unmap_c:     cover property (setup && next_err);

endmodule : rcmg_regs

/* dv/rcmg_regs_bench.sv */
`timescale 1ns/1ps
module rcmg_regs_bench;
  import rcmg_pkg::*;
  logic                       clk = 0, rst_b = 0, psel = 0, pen = 0, power_setpoint_command = 0, pdv = 0;
  logic [ADDR_W-1:0]          paddr = '0;
  logic [DATA_W-1:0]          pwdata = '0, prdata, rd;
  logic                       pready, pslverr, er;
  logic [NUM_DIODE*REG_W-1:0] pd = '0;
  logic [REG_W-1:0]           temp = '0, lopw = '0, lo_set;
  logic [NUM_CHAN*REG_W-1:0]  gain, rft;
  logic [NUM_CHAN-1:0]        automatic_gain;
  int                         failures = 0, cmp_count = 0;

  rcmg_regs #(.AVG_LOG(2)) dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(power_setpoint_command), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_PD_VALID(pdv), .I_PD_CURRENT(pd), .I_TEMP(temp), .I_LO_POWER(lopw),
    .O_GAIN_CTRL(gain), .O_RF_TARGET(rft), .O_AGC_EN(automatic_gain), .O_LO_SETPOINT(lo_set));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Bounded wait on pready so a stuck slave still reaches the verdict
  task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; power_setpoint_command <= w; paddr <= {idx, 2'h0}; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] exp);
    apb(1'b0, idx, '0);
    chk(nm, {16'h0000, exp}, rd);
    chk("slave error", 32'h0, {31'h0, er});
  endtask : rchk

  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk("gain reset", IDX_GCV, REG_RESET);
    rchk("setpoint reset", IDX_LO_SET, 16'h0000);
    rchk("min limit", IDX_LO_MIN, 16'hfc18);
    rchk("max limit", IDX_LO_MAX, 16'h03e8);
    chk("agc reset", 32'h0, {28'h0, automatic_gain});
  endtask : t_reset

  task automatic t_monitor;
    temp <= 16'h8000;
    lopw <= 16'hfe0c;
    repeat (3) @(posedge clk);
    rchk("temperature", IDX_TEMP, 16'h8000);
    rchk("oscillator power", IDX_LO_MON, 16'hfe0c);
  endtask : t_monitor

  task automatic t_reserved;
    apb(1'b1, IDX_RSVD + 16'h1, 32'h0000ffff);
    rchk("reserved low", IDX_RSVD, 16'h0000);
    rchk("reserved high", IDX_RSVD + 16'h1, 16'h0000);
    apb(1'b0, 16'h0000, '0);
    chk("unmapped error", 32'h1, {31'h0, er});
  endtask : t_reserved

  task automatic t_gain;
    for (int c = 0; c < NUM_CHAN; c++) begin
      apb(1'b1, IDX_GCV + 16'(c), 32'h1000 + 32'(c));
      settle();
      chk("gain out", 32'h1000 + 32'(c), 32'(gain[16*c +: 16]));
    end
    apb(1'b1, IDX_GAIN_MODE, 32'h4000);
    apb(1'b1, IDX_GAIN_MODE + 16'h2, 32'h8000);
    apb(1'b1, IDX_GCV, 32'hbeef);
    apb(1'b1, IDX_GCV + 16'h2, 32'hbeef);
    settle();
    chk("agc enable", 32'h1, {28'h0, automatic_gain});
    chk("gain held", 32'h1000, 32'(gain[15:0]));
    rchk("gain auto", IDX_GCV, 16'h1000);
    rchk("gain mode2", IDX_GCV + 16'h2, 16'h1002);
    apb(1'b1, IDX_RFT, 32'h8001);
    apb(1'b1, IDX_RFT + 16'h1, 32'h1234);
    settle();
    chk("target auto", 32'h8001, 32'(rft[15:0]));
    chk("target manual", 32'h0, 32'(rft[31:16]));
    rchk("target readback", IDX_RFT + 16'h1, 16'h1234);
  endtask : t_gain

  task automatic t_lo;
    logic [REG_W-1:0] wr [3] = '{16'h8000, 16'h7fff, 16'h0064};
    logic [REG_W-1:0] ex [3] = '{16'hfc18, 16'h03e8, 16'h0064};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, IDX_LO_SET, {16'h0, wr[i]});
      settle();
      chk("setpoint out", {16'h0, ex[i]}, {16'h0, lo_set});
      rchk("setpoint read", IDX_LO_SET, ex[i]);
    end
  endtask : t_lo

  // Constant samples make average, minimum and maximum all equal the sample
  task automatic t_photo;
    for (int d = 0; d < NUM_DIODE; d++) pd[16*d +: 16] <= 16'(16'h0100 * (d + 1));
    repeat (4) begin
      @(posedge clk);
      pdv <= 1'b1;
      @(posedge clk);
      pdv <= 1'b0;
    end
    repeat (4) @(posedge clk);
    for (int d = 0; d < NUM_DIODE; d++) rchk("diode avg", IDX_DIODE_AVG + 16'(d), 16'(16'h0100 * (d + 1)));
    for (int c = 0; c < NUM_CHAN; c++) begin
      rchk("chan cur", IDX_CHAN_CUR + 16'(c), 16'(16'h0100 * (4 * c + 3)));
      rchk("chan avg", IDX_CHAN_AVG + 16'(c), 16'(16'h0100 * (4 * c + 3)));
    end
    for (int p = 0; p < NUM_POL; p++) begin
      rchk("pol cur", IDX_POL_CUR + 16'(p), 16'(16'h0100 * (16 * p + 10)));
      rchk("pol avg", IDX_POL_AVG + 16'(p), 16'(16'h0100 * (16 * p + 10)));
      rchk("pol min", IDX_POL_MIN + 16'(p), 16'(16'h0100 * (16 * p + 10)));
      rchk("pol max", IDX_POL_MAX + 16'(p), 16'(16'h0100 * (16 * p + 10)));
    end
  endtask : t_photo

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_monitor();
    t_reserved();
    t_gain();
    t_lo();
    t_photo();
    stop_test();
  end
endmodule : rcmg_regs_bench
